// [sccd_consts.svh]
// Constants for the storage card command decoder: register offsets, codes, timing.
// Assumes a 25 MHz system clock and a 32-bit Avalon-MM slave with word addresses.
`ifndef SCCD_CONSTS_SVH
`define SCCD_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------------------
`define SCCD_OFS_FEATURE     4'h0
`define SCCD_OFS_SECCNT      4'h1
`define SCCD_OFS_SECNUM      4'h2
`define SCCD_OFS_CYL         4'h3
`define SCCD_OFS_DRVHEAD     4'h4
`define SCCD_OFS_COMMAND     4'h5
`define SCCD_OFS_STATUS      4'h6
`define SCCD_OFS_ALTSTAT     4'h7
`define SCCD_OFS_DEVCTRL     4'h8
`define SCCD_OFS_ERROR       4'h9
`define SCCD_OFS_BLKADDR     4'ha
`define SCCD_OFS_CARDCFG     4'hb
`define SCCD_OFS_DATA        4'hc

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SCCD_DH_LBA_BIT      6
`define SCCD_DH_DRV_BIT      4
`define SCCD_DC_SRST_BIT     2
`define SCCD_DC_NIEN_BIT     1
`define SCCD_CFG_IDE_BIT     0
`define SCCD_CFG_DRV_BIT     1
`define SCCD_CFG_SLEEP_BIT   2
`define SCCD_CFG_SLVF_BIT    3

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define SCCD_CMD_PWR_A       8'he5
`define SCCD_CMD_PWR_B       8'h98
`define SCCD_CMD_DIAG        8'h90
`define SCCD_CMD_ERASE       8'hc0
`define SCCD_CMD_FORMAT      8'h50
`define SCCD_CMD_WR_NOERASE  8'h38
`define SCCD_CMD_WR_BUF      8'he8
`define SCCD_CMD_WR_MULT     8'hc5
`define SCCD_CMD_WR_MULT_NE  8'hcd
`define SCCD_CMD_WR_VERIFY   8'h3c

// ----------------------------------------------------------------------------
// Result values
// ----------------------------------------------------------------------------
`define SCCD_SC_SLEEP        8'h00
`define SCCD_SC_IDLE         8'hff
`define SCCD_DIAG_OK         8'h01
`define SCCD_DIAG_SLAVE      8'h80
`define SCCD_ERR_ABORT       8'h04
`define SCCD_FILL_PATTERN    8'hff
`define SCCD_SECTOR_BYTES    10'h200

// ----------------------------------------------------------------------------
// Timing: times in ns, cycle counts derived at 40 ns per cycle
// ----------------------------------------------------------------------------
`define SCCD_CLK_NS          40
`define SCCD_BSY_MAX_NS      400
`define SCCD_DRQ2_MAX_NS     700000
`define SCCD_DRQ3_MAX_NS     20000000
`define SCCD_BSY_CYC         (`SCCD_BSY_MAX_NS / `SCCD_CLK_NS)
`define SCCD_DRQ2_CYC        (`SCCD_DRQ2_MAX_NS / `SCCD_CLK_NS)
`define SCCD_DRQ3_CYC        (`SCCD_DRQ3_MAX_NS / `SCCD_CLK_NS)

`endif

// [sccd_pkg.sv]
// Types for the storage card command decoder.
// Assumes sccd_consts.svh is available for the constants.
package sccd_pkg;

  // --------------------------------------------------------------------------
  // Acceptance classes and sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SCCD_CLS_ONE   = 2'b01,
    SCCD_CLS_TWO   = 2'b10,
    SCCD_CLS_THREE = 2'b11
  } sccd_class_t;

  typedef enum logic [2:0] {
    SCCD_ST_IDLE  = 3'b000,
    SCCD_ST_EXEC  = 3'b001,
    SCCD_ST_PREP  = 3'b010,
    SCCD_ST_XFER  = 3'b011,
    SCCD_ST_DONE  = 3'b100
  } sccd_state_t;

  // Task-file parameter set captured for one command
  typedef struct packed {
    logic [7:0]  feature_param;
    logic [7:0]  sector_count_param;
    logic [7:0]  sector_number_param;
    logic [15:0] cylinder_param;
    logic [7:0]  drive_head_param;
  } sccd_taskfile_t;

  // All block state
  typedef struct packed {
    sccd_taskfile_t tf;
    logic [7:0]     cmd;
    sccd_class_t    cls;
    sccd_state_t    st;
    logic [23:0]    timer;
    logic [9:0]     byte_cnt;
    logic [8:0]     fmt_left;
    logic [27:0]    blk_addr;
    logic           busy_flag;
    logic           data_request_flag;
    logic           err;
    logic           wfault;
    logic           ready;
    logic [7:0]     error_code;
    logic           intr_pend;
    logic           nien;
    logic           srst;
    logic [3:0]     cfg;
    logic           wait_done;
    logic [31:0]    rdata;
    logic           rvalid;
    logic           irq;
    logic           fill_we;
    logic [7:0]     fill_byte;
  } sccd_state_rec_t;

endpackage

// [sccd_decoder.sv]
// Command decoder and sequencer of the storage card task-file interface.
// Assumes an Avalon-MM master with single-word accesses; media is outside.
// Functional notes
// - Busy rises within 400 ns of command
// - Class two: request within 700 us
// - Class three: request within 20 ms
// - Write, long, buffer, format codes are class two
// - C5h, CDh, 3Ch class three, others one
// - Use only parameters valid for the command
// - Drive-only commands ignore the head field
// - Block address from sector, cylinder, head
// - 98h and E5h both query power
// - Sleep query returns count 00h, interrupt
// - Idle query returns count FFh, interrupt
// - 90h runs internal self-tests
// - Diagnostic result code goes to error register
// - Card-bus mode: only selected drive diagnoses
// - Disk mode: diagnose regardless of drive bit
// - Slave failure reported as code 8Xh
// - C0h pre-erases the addressed sectors
// - Pre-erase moves no data, may write-fault
// - Format fills track with fixed pattern
// - Format takes one sector, discards it
// - Block-mode format count zero means 256
// - Block mode honoured only where supported
`include "sccd_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sccd_decoder
  import sccd_pkg::*;
#(
  parameter int unsigned DRQ2_CYCLES = `SCCD_DRQ2_CYC,
  parameter int unsigned DRQ3_CYCLES = `SCCD_DRQ3_CYC,
  parameter int unsigned EXEC_CYCLES = 4
)(
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  input  wire logic        diag_fault_in,
  input  wire logic [2:0]  diag_code_in,
  input  wire logic        media_fault_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             irq_out,
  output logic             fill_we_out,
  output logic      [7:0]  fill_byte_out,
  output logic      [27:0] media_addr_out
);

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  if (DRQ2_CYCLES < 1 || DRQ3_CYCLES < 1 || EXEC_CYCLES < 1 ||
      DRQ2_CYCLES > 24'hffffff || DRQ3_CYCLES > 24'hffffff)
  begin : g_bad_param
    $error("sccd_decoder: timing parameter out of range");
  end

  // Timers are 24 bits wide; the check above keeps both request limits inside that width,
  // so DRQ2_C and DRQ3_C never drop a set bit; EXEC_CYCLES has no upper check
  localparam logic [23:0] DRQ2_C = DRQ2_CYCLES[23:0];
  localparam logic [23:0] DRQ3_C = DRQ3_CYCLES[23:0];
  localparam logic [23:0] EXEC_C = EXEC_CYCLES[23:0];

  sccd_state_rec_t s_reg;
  sccd_state_rec_t s_next;

  // --------------------------------------------------------------------------
  // Command classification
  // --------------------------------------------------------------------------
  function automatic sccd_class_t classify(input logic [7:0] c);
    sccd_class_t k;
    k = SCCD_CLS_ONE;
    if (c == 8'h30 || c == 8'h31 || c == `SCCD_CMD_WR_NOERASE ||
        c == 8'h32 || c == 8'h33 || c == `SCCD_CMD_WR_BUF ||
        c == `SCCD_CMD_FORMAT)
      k = SCCD_CLS_TWO;
    if (c == `SCCD_CMD_WR_MULT || c == `SCCD_CMD_WR_MULT_NE ||
        c == `SCCD_CMD_WR_VERIFY)
      k = SCCD_CLS_THREE;
    return k;
  endfunction

  // Listed command set; anything else is aborted
  function automatic logic known(input logic [7:0] c);
    logic r;
    r = 1'b0;
    unique case (c)
      8'he5, 8'h98, 8'h90, 8'hc0, 8'h50, 8'hec, 8'he3, 8'h97, 8'he1,
      8'h95, 8'h91, 8'he4, 8'h22, 8'h23, 8'hc4, 8'h20, 8'h21, 8'h40,
      8'h41, 8'h03, 8'hf6, 8'hf3, 8'hf4, 8'hf5, 8'hf1, 8'hf2, 8'hef,
      8'hc6, 8'he6, 8'h99, 8'he2, 8'h96, 8'he0, 8'h94, 8'h87, 8'he8,
      8'h32, 8'h33, 8'hc5, 8'hcd, 8'h30, 8'h31, 8'h38, 8'h3c: r = 1'b1;
      default: r = (c[7:4] == 4'h1) || (c[7:4] == 4'h7);
    endcase
    return r;
  endfunction

  // Commands whose address may be a block address
  function automatic logic lba_ok(input logic [7:0] c);
    logic r;
    r = 1'b0;
    unique case (c)
      8'hc0, 8'h50, 8'h22, 8'h23, 8'hc4, 8'h20, 8'h21, 8'h40, 8'h41,
      8'h87, 8'h32, 8'h33, 8'hc5, 8'hcd, 8'h30, 8'h31, 8'h38, 8'h3c: r = 1'b1;
      default: r = (c[7:4] == 4'h7);
    endcase
    return r;
  endfunction

  // Commands that use the head field; the rest are drive-only
  function automatic logic head_used(input logic [7:0] c);
    return lba_ok(c) || c == 8'h91 || c == 8'hf5;
  endfunction

  // Commands that use the sector count register
  function automatic logic count_used(input logic [7:0] c);
    logic r;
    r = 1'b0;
    unique case (c)
      8'hc0, 8'h50, 8'he3, 8'h97, 8'h91, 8'hc4, 8'h20, 8'h21, 8'h40,
      8'h41, 8'hc6, 8'h87, 8'hc5, 8'hcd, 8'h30, 8'h31, 8'h38, 8'h3c: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic        wr;
    logic        rd;
    logic [7:0]  wb;
    logic [7:0]  c;
    logic [7:0]  dh;
    logic [7:0]  stat;
    logic        block_address_mode;
    logic        for_me;
    s_next = s_reg;
    wr = avs_write_in && s_reg.wait_done && avs_byteenable_in[0];
    rd = avs_read_in && !s_reg.wait_done;
    wb = avs_writedata_in[7:0];
    c = s_reg.cmd;
    dh = s_reg.tf.drive_head_param;
    block_address_mode = dh[`SCCD_DH_LBA_BIT] && lba_ok(c);
    // Diagnostics in card-bus mode run only on the selected card
    for_me = s_reg.cfg[`SCCD_CFG_IDE_BIT] ||
             (dh[`SCCD_DH_DRV_BIT] == s_reg.cfg[`SCCD_CFG_DRV_BIT]);
    stat = {s_reg.busy_flag, s_reg.ready, s_reg.wfault, s_reg.ready,
            s_reg.data_request_flag, 1'b0, 1'b0, s_reg.err};
    s_next.fill_we = 1'b0;
    s_next.rvalid = 1'b0;

    // One-cycle wait state: answer lands on the second request cycle.
    // Writes land at the edge where waitrequest is sampled low, so a master that gives up early
    // changes nothing; reads fetch in the first cycle so the data is a flop output
    s_next.wait_done = (avs_read_in || avs_write_in) && !s_reg.wait_done;

    // Register reads; status read clears the pending interrupt
    s_next.rdata = 32'h0000_0000;
    if (rd)
    begin
      unique case (avs_address_in)
        `SCCD_OFS_FEATURE: s_next.rdata[7:0] = s_reg.tf.feature_param;
        `SCCD_OFS_SECCNT:  s_next.rdata[7:0] = s_reg.tf.sector_count_param;
        `SCCD_OFS_SECNUM:  s_next.rdata[7:0] = s_reg.tf.sector_number_param;
        `SCCD_OFS_CYL:     s_next.rdata[15:0] = s_reg.tf.cylinder_param;
        `SCCD_OFS_DRVHEAD: s_next.rdata[7:0] = dh;
        `SCCD_OFS_COMMAND: s_next.rdata[7:0] = c;
        `SCCD_OFS_STATUS:
        begin
          s_next.rdata[7:0] = stat;
          s_next.intr_pend = 1'b0;
        end
        `SCCD_OFS_ALTSTAT: s_next.rdata[7:0] = stat;
        `SCCD_OFS_DEVCTRL: s_next.rdata[7:0] = {5'h00, s_reg.srst, s_reg.nien, 1'b0};
        `SCCD_OFS_ERROR:   s_next.rdata[7:0] = s_reg.error_code;
        `SCCD_OFS_BLKADDR: s_next.rdata[27:0] = s_reg.blk_addr;
        `SCCD_OFS_CARDCFG: s_next.rdata[3:0] = s_reg.cfg;
        default:           s_next.rdata = 32'h0000_0000;
      endcase
    end

    // Control writes are taken even while busy
    if (wr && avs_address_in == `SCCD_OFS_DEVCTRL)
    begin
      s_next.srst = wb[`SCCD_DC_SRST_BIT];
      s_next.nien = wb[`SCCD_DC_NIEN_BIT];
    end
    if (wr && avs_address_in == `SCCD_OFS_CARDCFG)
      s_next.cfg = wb[3:0];

    // Task file writes are locked out while busy; host must wait
    if (wr && !s_reg.busy_flag)
    begin
      unique case (avs_address_in)
        `SCCD_OFS_FEATURE: s_next.tf.feature_param = wb;
        `SCCD_OFS_SECCNT:  s_next.tf.sector_count_param = wb;
        `SCCD_OFS_SECNUM:  s_next.tf.sector_number_param = wb;
        `SCCD_OFS_CYL:     s_next.tf.cylinder_param = avs_writedata_in[15:0];
        `SCCD_OFS_DRVHEAD: s_next.tf.drive_head_param = wb;
        `SCCD_OFS_COMMAND:
        begin
          s_next.cmd = wb;
          s_next.cls = classify(wb);
          s_next.busy_flag = 1'b1;
          s_next.err = 1'b0;
          s_next.wfault = 1'b0;
          s_next.st = SCCD_ST_EXEC;
          s_next.timer = 24'h000000;
        end
        default: s_next.st = s_reg.st;
      endcase
    end

    // Command sequencer
    // Data-moving commands leave EXEC for PREP at once; class one finishes in EXEC
    // after EXEC_CYCLES cycles, except the power query and unknown codes, which need no wait
    unique case (s_reg.st)
      SCCD_ST_IDLE: s_next.timer = 24'h000000;
      SCCD_ST_EXEC:
      begin
        // Address: block form or cylinder/head/sector, valid fields only
        if (block_address_mode)
          s_next.blk_addr = {dh[3:0], s_reg.tf.cylinder_param,
                             s_reg.tf.sector_number_param};
        else
          s_next.blk_addr = {(head_used(c) ? dh[3:0] : 4'h0),
                             s_reg.tf.cylinder_param,
                             s_reg.tf.sector_number_param};
        // Format count: zero means 256, only from the count in block mode
        s_next.fmt_left = (block_address_mode && count_used(c) && s_reg.tf.sector_count_param != 8'h00) ?
                          {1'b0, s_reg.tf.sector_count_param} : 9'h100;
        if (!block_address_mode)
          s_next.fmt_left = 9'h001;
        if (!known(c))
        begin
          s_next.err = 1'b1;
          s_next.error_code = `SCCD_ERR_ABORT;
          s_next.st = SCCD_ST_DONE;
        end
        else if (s_reg.cls != SCCD_CLS_ONE)
          s_next.st = SCCD_ST_PREP;
        else if (c == `SCCD_CMD_PWR_A || c == `SCCD_CMD_PWR_B)
        begin
          s_next.tf.sector_count_param = s_reg.cfg[`SCCD_CFG_SLEEP_BIT] ?
                                         `SCCD_SC_SLEEP : `SCCD_SC_IDLE;
          s_next.st = SCCD_ST_DONE;
        end
        else if (s_reg.timer == EXEC_C - 24'h000001)
        begin
          if (c == `SCCD_CMD_DIAG && for_me)
          begin
            s_next.error_code = diag_fault_in ? {5'h00, diag_code_in} : `SCCD_DIAG_OK;
            if (s_reg.cfg[`SCCD_CFG_IDE_BIT] && s_reg.cfg[`SCCD_CFG_SLVF_BIT])
              s_next.error_code = `SCCD_DIAG_SLAVE | {5'h00, diag_code_in};
          end
          if (c == `SCCD_CMD_ERASE && media_fault_in)
          begin
            s_next.wfault = 1'b1;
            s_next.err = 1'b1;
          end
          s_next.st = SCCD_ST_DONE;
        end
        else
          s_next.timer = s_reg.timer + 24'h000001;
      end
      SCCD_ST_PREP:
      begin
        // Buffer set-up; request raised well inside the class limit
        // Limits below EXEC_CYCLES would never open the window, so keep them above
        s_next.timer = s_reg.timer + 24'h000001;
        s_next.byte_cnt = 10'h000;
        if (s_reg.timer >= EXEC_C - 24'h000001 &&
            (s_reg.timer < DRQ2_C || s_reg.cls == SCCD_CLS_THREE) &&
            s_reg.timer < DRQ3_C)
        begin
          s_next.data_request_flag = 1'b1;
          s_next.busy_flag = 1'b0;
          s_next.st = SCCD_ST_XFER;
        end
      end
      SCCD_ST_XFER:
      begin
        // Host streams one sector; format data is accepted and dropped
        // The count only moves on data-port writes, other offsets pass through
        if (wr && avs_address_in == `SCCD_OFS_DATA)
        begin
          s_next.byte_cnt = s_reg.byte_cnt + 10'h001;
          if (s_reg.byte_cnt == `SCCD_SECTOR_BYTES - 10'h001)
          begin
            s_next.data_request_flag = 1'b0;
            s_next.busy_flag = 1'b1;
            s_next.st = SCCD_ST_DONE;
          end
        end
      end
      SCCD_ST_DONE:
      begin
        // Format fills each sector with the fixed pattern
        // Busy stays up until the last fill strobe has gone out
        if (c == `SCCD_CMD_FORMAT && s_reg.fmt_left != 9'h000)
        begin
          s_next.fill_we = 1'b1;
          s_next.fill_byte = `SCCD_FILL_PATTERN;
          s_next.fmt_left = s_reg.fmt_left - 9'h001;
          s_next.blk_addr = s_reg.blk_addr + 28'h0000001;
        end
        else
        begin
          s_next.busy_flag = 1'b0;
          s_next.intr_pend = 1'b1;
          s_next.st = SCCD_ST_IDLE;
        end
      end
      default: s_next.st = SCCD_ST_IDLE;
    endcase

    // Status read never loses a completion arriving in the same cycle
    s_next.irq = s_next.intr_pend && !s_next.nien;
    s_next.rvalid = rd;
    if (s_reg.srst)
    begin
      s_next.st = SCCD_ST_IDLE;
      s_next.busy_flag = 1'b1;
      s_next.data_request_flag = 1'b0;
      s_next.intr_pend = 1'b0;
      s_next.irq = 1'b0;
      s_next.fill_we = 1'b0;
    end
    else if (s_reg.st == SCCD_ST_IDLE && s_reg.busy_flag && !wr)
      s_next.busy_flag = 1'b0;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s_reg <= '0;
      s_reg.ready <= 1'b1;
      s_reg.error_code <= `SCCD_DIAG_OK;
      s_reg.cls <= SCCD_CLS_ONE;
    end
    else
      s_reg <= s_next;
  end

  // Outputs straight from flip-flops
  // Waitrequest is the one exception: it must rise in the very cycle of the
  // request, which no flop fed from the request can do
  assign avs_readdata_out    = s_reg.rdata;
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !s_reg.wait_done;
  assign irq_out             = s_reg.irq;
  assign fill_we_out         = s_reg.fill_we;
  assign fill_byte_out       = s_reg.fill_byte;
  assign media_addr_out      = s_reg.blk_addr;

endmodule

`default_nettype wire

// [sccd_decoder_assertions.sv]
// Checker for the command decoder, watching the top-level ports only.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/1ps
`default_nettype none
module sccd_chk (
  input wire logic        sys_clk_in,
  input wire logic        nrst_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic        diag_fault_in,
  input wire logic [2:0]  diag_code_in,
  input wire logic        media_fault_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        irq_out,
  input wire logic        fill_we_out,
  input wire logic [7:0]  fill_byte_out,
  input wire logic [27:0] media_addr_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  // Accepted reads and writes; status and alternate status share [3:1]
  wire acc_rd = avs_read_in && !avs_waitrequest_out;
  wire acc_wr = avs_write_in && !avs_waitrequest_out;
  wire st_adr = avs_address_in[3:1] == 3'h3;
  // ---------------------------------------------------------------------------
  // Bus contract and command results
  // ---------------------------------------------------------------------------
  property p_wfirst; ($rose(avs_read_in) || $rose(avs_write_in)) |-> avs_waitrequest_out; endproperty
  a_wfirst: assert property (p_wfirst) else $error("no wait in first request cycle");
  property p_wans; (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
  a_wans: assert property (p_wans) else $error("more than one wait cycle");
  property p_unmap; acc_rd && avs_address_in > 4'hc |-> avs_readdata_out == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_bsy; acc_wr && avs_address_in == 4'h5 ##3 acc_rd && st_adr |-> avs_readdata_out[7]; endproperty
  a_bsy: assert property (p_bsy) else $error("busy late after command");
  property p_drq; acc_rd && st_adr && avs_readdata_out[3] |-> !avs_readdata_out[7]; endproperty
  a_drq: assert property (p_drq) else $error("busy with data request");
  property p_fill; fill_we_out |-> fill_byte_out == 8'hff; endproperty
  a_fill: assert property (p_fill) else $error("fill byte not pattern");
  property p_irqclr; acc_rd && avs_address_in == 4'h6 && !avs_readdata_out[7] |-> ##[1:2] !irq_out; endproperty
  a_irqclr: assert property (p_irqclr) else $error("status read kept irq");
  property p_altkeep; acc_rd && avs_address_in == 4'h7 && irq_out |=> irq_out; endproperty
  a_altkeep: assert property (p_altkeep) else $error("alt status read cleared irq");
  c_cmd: cover property (acc_wr && avs_address_in == 4'h5);
  c_fill: cover property (fill_we_out);
  c_irq: cover property ($rose(irq_out));
endmodule
bind sccd_decoder sccd_chk chk_u (.*);
`default_nettype wire

// [sccd_media_model.sv]
// Media and self-test stand-in on the decoder's fault and fill pins.
// Assumes the bench picks the fault to report before each command.
`timescale 1ns/1ps
`default_nettype none
module sccd_media_model (
  input  wire logic       sys_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       fault_in,
  input  wire logic [2:0] code_in,
  input  wire logic       fill_we_in,
  input  wire logic [7:0] fill_byte_in,
  output logic            diag_fault_out,
  output logic [2:0]      diag_code_out,
  output logic            media_fault_out,
  output logic [9:0]      fill_cnt_out,
  output logic            fill_bad_out
);
  // Faults are levels, so the sampling moment in the decoder is free
  assign diag_fault_out  = fault_in;
  assign diag_code_out   = code_in;
  assign media_fault_out = fault_in;
  // Count fill strobes; a byte off the pattern sticks until reset
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      fill_cnt_out <= 10'h0;
      fill_bad_out <= 1'b0;
    end
    else if (fill_we_in)
    begin
      fill_cnt_out <= fill_cnt_out + 10'h1;
      fill_bad_out <= fill_bad_out | (fill_byte_in != 8'hff);
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
// Bench for the command decoder: one task per scenario over Avalon-MM.
// Assumes one wait cycle per access and small data-request counts.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        flt = 1'b0;
  logic [2:0]  code = 3'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic        wq, irq, fwe, dflt, mflt, fbad;
  logic [2:0]  dcode;
  logic [7:0]  fbyte;
  logic [27:0] maddr;
  logic [9:0]  fcnt;
  int          fail_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  always #20 clk = ~clk;
  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
  end
  sccd_decoder #(.DRQ2_CYCLES(8), .DRQ3_CYCLES(8)) dut_u (
    .sys_clk_in(clk), .nrst_in(nrst), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
    .diag_fault_in(dflt), .diag_code_in(dcode), .media_fault_in(mflt),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wq), .irq_out(irq),
    .fill_we_out(fwe), .fill_byte_out(fbyte), .media_addr_out(maddr));
  sccd_media_model media_u (
    .sys_clk_in(clk), .nrst_in(nrst), .fault_in(flt), .code_in(code),
    .fill_we_in(fwe), .fill_byte_in(fbyte), .diag_fault_out(dflt),
    .diag_code_out(dcode), .media_fault_out(mflt), .fill_cnt_out(fcnt), .fill_bad_out(fbad));
  // ---------------------------------------------------------------------------
  // Bus access, comparison and polling
  // ---------------------------------------------------------------------------
  // Held until waitrequest is sampled low; read data taken at that same edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wq !== 1'b0)
      @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string n);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  // Polls the alternate status so a pending interrupt survives
  task automatic wt(input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    bus(0, 4'h7, 0);
    while ((q[7:0] & m) !== v && n < 3000)
    begin
      bus(0, 4'h7, 0);
      n++;
    end
    chk({24'h0, v}, {24'h0, q[7:0] & m}, "status poll");
  endtask
  task automatic t_power();
    logic [7:0] pc [2] = '{8'he5, 8'h98};
    foreach (pc[i])
    begin
      bus(1, 4'hb, 32'h0);
      bus(1, 4'h5, pc[i]);
      wt(8'h80, 8'h00);
      bus(0, 4'h1, 0);
      chk(32'hff, q, "idle count");
      chk(32'h1, irq, "irq");
      bus(0, 4'h6, 0);
      repeat (2) @(posedge clk);
      chk(32'h0, irq, "irq cleared");
      bus(1, 4'hb, 32'h4);
      bus(1, 4'h5, pc[i]);
      wt(8'h80, 8'h00);
      bus(0, 4'h1, 0);
      chk(32'h0, q, "sleep count");
    end
    bus(1, 4'h8, 32'h2);
    bus(1, 4'h5, 32'he5);
    wt(8'h80, 8'h00);
    chk(32'h0, irq, "masked irq");
    bus(0, 4'h6, 0);
    bus(1, 4'h8, 32'h0);
  endtask
  task automatic t_diag();
    bus(1, 4'hb, 32'h0);
    bus(1, 4'h4, 32'h0f);
    for (int k = 1; k < 6; k++)
    begin
      flt <= (k != 1);
      code <= k[2:0];
      bus(1, 4'h5, 32'h90);
      wt(8'h80, 8'h00);
      bus(0, 4'h9, 0);
      chk(k, q, "diag code");
    end
    chk(32'h0, {28'h0, maddr[27:24]}, "drive-only head");
    flt <= 1'b0;
    bus(1, 4'hb, 32'h9);
    bus(1, 4'h4, 32'h10);
    bus(1, 4'h5, 32'h90);
    wt(8'h80, 8'h00);
    bus(0, 4'h9, 0);
    chk(32'h80, q & 32'hf0, "slave code");
    bus(1, 4'hb, 32'h0);
    bus(1, 4'h5, 32'h90);
    wt(8'h80, 8'h00);
    bus(0, 4'h9, 0);
    chk(32'h0, q == 32'h1, "other drive ran");
  endtask
  task automatic t_abort();
    bus(1, 4'h5, 32'h00);
    wt(8'h80, 8'h00);
    chk(32'h1, q & 32'h1, "error flag");
    bus(0, 4'h9, 0);
    chk(32'h4, q, "abort code");
    bus(0, 4'h6, 0);
  endtask
  task automatic t_erase();
    flt <= 1'b1;
    bus(1, 4'h2, 32'h11);
    bus(1, 4'h3, 32'h3322);
    bus(1, 4'h4, 32'he4);
    bus(1, 4'h5, 32'hc0);
    wt(8'h80, 8'h00);
    chk(32'h20, q & 32'h20, "write fault");
    bus(0, 4'ha, 0);
    chk(32'h4332211, q, "block address");
    chk(32'h4332211, {4'h0, maddr}, "media address");
    flt <= 1'b0;
  endtask
  task automatic t_xfer(input logic [7:0] c, input logic [7:0] sc, input logic [7:0] dh, input logic [31:0] nf);
    logic [9:0] f0;
    f0 = fcnt;
    bus(1, 4'h1, sc);
    bus(1, 4'h4, dh);
    bus(1, 4'h5, c);
    wt(8'h88, 8'h08);
    chk(32'h08, q & 32'h88, "data request");
    repeat (512) bus(1, 4'hc, 32'ha5);
    wt(8'h80, 8'h00);
    chk(nf, fcnt - f0, "fills");
    chk(32'h0, fbad, "fill byte");
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well above the longest run of the sequence
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      fail_count++;
      conclude();
    end
  end
  initial
  begin
    logic [7:0] wc [5] = '{8'h38, 8'he8, 8'hc5, 8'hcd, 8'h3c};
    wait (nrst === 1'b1);
    bus(0, 4'h6, 0);
    chk(32'h50, q, "reset status");
    bus(0, 4'hf, 0);
    chk(32'h0, q, "unmapped read");
    t_power();
    t_diag();
    t_abort();
    t_erase();
    t_xfer(8'h50, 8'h00, 8'h40, 256);
    t_xfer(8'h50, 8'h05, 8'h00, 1);
    foreach (wc[i]) t_xfer(wc[i], 8'h01, 8'h00, 0);
    conclude();
  end
endmodule
`default_nettype wire
